// File: fcor_chk_sva.sv
// port assertions for the flash clock and option register block
`timescale 1ns/10ps
module fcor_chk
   import fcor_pkg::*;
(
   // clock and reset
   input wire logic         clock_i,
   input wire logic         reset_n_i,
   // register port
   input wire fcor_addr_t   reg_addr_i,
   input wire logic         reg_write_i,
   input wire logic         reg_read_i,
   input wire fcor_byte_t   reg_rdata_o,
   // flash engine side
   input wire logic         op_request_i,
   input wire logic         blank_check_ok_i,
   input wire logic         op_allowed_o,
   input wire logic         op_accept_o,
   input wire logic         op_blocked_o,
   // memory gate and options
   input wire fcor_source_e mem_source_i,
   input wire logic         mem_write_i,
   input wire fcor_byte_t   mem_rdata_i,
   input wire logic         mem_write_en_o,
   input wire fcor_byte_t   mem_rdata_o,
   input wire logic         secure_o,
   input wire logic         redirection_disable_o,
   input wire logic         backdoor_key_enable_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_opt_read;
      reg_read_i && reg_addr_i == 4'h1;
   endsequence
   sequence s_div_write;
      reg_write_i && reg_addr_i == 4'h0;
   endsequence
   sequence s_debug_req;
      mem_source_i == FCOR_SRC_DEBUG;
   endsequence
   a_opt_zero_bits: assert property (s_opt_read |=> reg_rdata_o[5:2] == 4'h0)
      else $error("option bits 5 to 2 not zero");
   a_opt_code_state: assert property (s_opt_read |=> secure_o == (reg_rdata_o[1:0] != 2'h2))
      else $error("secure flag disagrees with code");
   a_opt_write_kept: assert property (reg_write_i && reg_addr_i == 4'h1 |=>
      $stable(redirection_disable_o) && $stable(backdoor_key_enable_o))
      else $error("option changed by write");
   a_div_allows_op: assert property (s_div_write |-> ##2 op_allowed_o)
      else $error("loaded flag not set by write");
   a_op_refused: assert property (op_request_i && !op_allowed_o && !$past(reg_write_i) |=>
      op_blocked_o && !op_accept_o)
      else $error("operation not blocked");
   a_op_taken: assert property (op_request_i && op_allowed_o |=> op_accept_o && !op_blocked_o)
      else $error("operation not accepted");
   a_debug_blocked: assert property (s_debug_req ##1 secure_o |->
      mem_rdata_o == 8'h00 && !mem_write_en_o)
      else $error("debug access not blocked");
   a_open_read: assert property (!secure_o |=> mem_rdata_o == $past(mem_rdata_i))
      else $error("open read data altered");
   a_open_write: assert property (!secure_o && mem_write_i |=> mem_write_en_o)
      else $error("open write dropped");
   a_blank_unlock: assert property (blank_check_ok_i |-> ##[1:2] !secure_o)
      else $error("blank check did not unsecure");
endmodule // fcor_chk

bind fcor_flash_clock_option fcor_chk i_chk (.clock_i, .reset_n_i, .reg_addr_i, .reg_write_i, .reg_read_i,
   .reg_rdata_o, .op_request_i, .blank_check_ok_i, .op_allowed_o, .op_accept_o, .op_blocked_o, .mem_source_i,
   .mem_write_i, .mem_rdata_i, .mem_write_en_o, .mem_rdata_o, .secure_o, .redirection_disable_o,
   .backdoor_key_enable_o);

// File: fcor_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef FCOR_DEFINES_SVH
`define FCOR_DEFINES_SVH

`define FCOR_ADDR_CLOCK_DIVIDER  4'h0
`define FCOR_ADDR_OPTION_LATCH   4'h1
`define FCOR_ADDR_SECURITY_CTRL  4'h2
`define FCOR_ADDR_STATUS         4'h3

`define FCOR_BIT_LOADED          7
`define FCOR_BIT_PRESCALE        6
`define FCOR_BIT_KEY_ENABLE      7
`define FCOR_BIT_REDIR_DISABLE   6

`define FCOR_DIVIDER_RESET       8'h00
`define FCOR_OPTION_RESET        8'h00
`define FCOR_SECURE_UNLOCKED     2'h2
`define FCOR_PRESCALE_COUNT      3'h7
`define FCOR_KEY_BYTES           4'h8

`endif

// File: fcor_flash_clock_option.sv
// flash clock divider, option latch, security state and backdoor key logic
`timescale 1ns/10ps
`include "fcor_defines.svh"

// What this block does
// RL1: divisor and prescale bits take only the first write after reset.
// RL2: bit 7 is read-only loaded flag, set by first write.
// RL3: program and erase blocked until loaded flag is one.
// RL4: prescale bit selects bus clock or bus clock divided by eight.
// RL5: divider divides selected input by divisor field plus one.
// RL6: software keeps the flash clock between 150 and 200 kHz.
// RL7: each program or erase pulse is one flash clock cycle.
// RL8: option latch loads the nonvolatile option byte at reset release.
// RL9: option bits 5 to 2 always read zero.
// RL10: option latch readable anytime, writes leave it unchanged.
// RL11: software reprograms option byte then resets to change options.
// RL12: key enable bit gates the eight-byte in-order backdoor key.
// RL13: key writes count only from secure user firmware, never debug.
// RL14: redirection disable bit turns vector redirection off when one.
// RL15: security code unsecured only for pattern 1:0.
// RL16: while secure, unsecured sources cannot reach RAM or flash.
// RL17: security code becomes 1:0 after key match or blank check.
// RL18: blocked secure access ignores writes and reads zero.
// RL19: divider counter pulses every divisor plus one inputs, restarts on load.
module fcor_flash_clock_option (
   // clock and reset
   input  wire logic                  clock_i,
   input  wire logic                  reset_n_i,
   // register port
   input  wire fcor_pkg::fcor_addr_t  reg_addr_i,
   input  wire fcor_pkg::fcor_byte_t  reg_wdata_i,
   input  wire logic                  reg_write_i,
   input  wire logic                  reg_read_i,
   output fcor_pkg::fcor_byte_t       reg_rdata_o,
   // nonvolatile option byte and key programming
   input  wire fcor_pkg::fcor_byte_t  nonvolatile_option_byte_i,
   input  wire logic                  key_prog_en_i,
   input  wire logic [2:0]            key_prog_addr_i,
   input  wire fcor_pkg::fcor_byte_t  key_prog_data_i,
   // flash engine side
   input  wire logic                  op_request_i,
   input  wire logic                  blank_check_ok_i,
   output logic                       op_allowed_o,
   output logic                       op_accept_o,
   output logic                       op_blocked_o,
   output logic                       internal_flash_clock_o,
   output logic                       flash_pulse_o,
   // memory access gate
   input  wire fcor_pkg::fcor_source_e mem_source_i,
   input  wire logic                  mem_from_secure_i,
   input  wire logic                  mem_write_i,
   input  wire fcor_pkg::fcor_byte_t  mem_rdata_i,
   output logic                       mem_write_en_o,
   output fcor_pkg::fcor_byte_t       mem_rdata_o,
   // option outputs
   output logic                       secure_o,
   output logic                       redirection_disable_o,
   output logic                       backdoor_key_enable_o
);
   import fcor_pkg::*;

   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   logic             divisor_loaded_flag_q;
   logic             prescale_by_eight_q;
   logic [5:0]       divisor_field_q;
   logic [7:0]       flash_option_latch_q;
   logic             option_captured_q;
   logic [1:0]       security_code_q;
   logic             key_access_q;
   fcor_key_state_e  key_state_q;
   logic [2:0]       key_index_q;
   logic             key_mismatch_q;
   logic [7:0]       key_byte_q;
   logic             key_cmp_pending_q;
   logic [7:0]       key_store_rdata;
   logic             div_load;
   logic             unsecured;

   function automatic logic is_write(input fcor_addr_t a, input fcor_addr_t t, input logic w);
      is_write = w && (a == t);
   endfunction

   // divisor register takes write only while unloaded
   assign div_load = is_write(reg_addr_i, `FCOR_ADDR_CLOCK_DIVIDER, reg_write_i) && !divisor_loaded_flag_q;

   // RL15: only 1:0 unsecured
   assign unsecured = (security_code_q == `FCOR_SECURE_UNLOCKED);

   // ------------------------------------------------------------
   // clock divider register
   // ------------------------------------------------------------
   // RL1: first write only
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prescale_by_eight_q <= 1'b0;
         divisor_field_q     <= 6'h00;
      end else if (div_load) begin
         prescale_by_eight_q <= reg_wdata_i[`FCOR_BIT_PRESCALE];
         divisor_field_q     <= reg_wdata_i[5:0];
      end
   end

   // RL2: loaded flag set by first write
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         divisor_loaded_flag_q <= 1'b0;
      end else if (div_load) begin
         divisor_loaded_flag_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // flash clock generation
   // ------------------------------------------------------------
   logic [2:0] pre_cnt_q;
   logic [5:0] div_cnt_q;
   logic       div_tick;

   // RL4: divide-by-eight prescaler
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pre_cnt_q <= 3'h0;
      end else if (div_load) begin
         pre_cnt_q <= 3'h0;
      end else begin
         pre_cnt_q <= pre_cnt_q + 3'h1;
      end
   end

   assign div_tick = divisor_loaded_flag_q && (!prescale_by_eight_q || pre_cnt_q == `FCOR_PRESCALE_COUNT);

   // RL19: counter restarts on load
   // RL5: divide by divisor plus one
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_cnt_q <= 6'h00;
      end else if (div_load) begin
         div_cnt_q <= 6'h00;
      end else if (div_tick) begin
         div_cnt_q <= (div_cnt_q >= divisor_field_q) ? 6'h00 : div_cnt_q + 6'h01;
      end
   end

   // RL7: one pulse per flash clock cycle
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flash_pulse_o          <= 1'b0;
         internal_flash_clock_o <= 1'b0;
      end else begin
         flash_pulse_o          <= div_tick && (div_cnt_q >= divisor_field_q);
         internal_flash_clock_o <= divisor_loaded_flag_q && (div_cnt_q <= {1'b0, divisor_field_q[5:1]});
      end
   end

   // RL3: operations gated by loaded flag
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         op_allowed_o <= 1'b0;
         op_accept_o  <= 1'b0;
         op_blocked_o <= 1'b0;
      end else begin
         op_allowed_o <= divisor_loaded_flag_q;
         op_accept_o  <= op_request_i && divisor_loaded_flag_q;
         op_blocked_o <= op_request_i && !divisor_loaded_flag_q;
      end
   end

   // ------------------------------------------------------------
   // option latch
   // ------------------------------------------------------------
   // RL8: capture nonvolatile byte at reset release
   // RL10: bus writes never reach the latch
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flash_option_latch_q <= `FCOR_OPTION_RESET;
         option_captured_q    <= 1'b0;
      end else if (!option_captured_q) begin
         // RL9: bits 5 to 2 forced to zero
         flash_option_latch_q <= {nonvolatile_option_byte_i[7:6], 4'h0, nonvolatile_option_byte_i[1:0]};
         option_captured_q    <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // backdoor key entry
   // ------------------------------------------------------------
   logic key_write;
   logic key_ctrl_write;

   // RL13: only secure user firmware counts
   assign key_write = key_access_q && is_write(reg_addr_i, `FCOR_ADDR_STATUS, reg_write_i)
                      && mem_source_i == FCOR_SRC_CPU && mem_from_secure_i;
   assign key_ctrl_write = is_write(reg_addr_i, `FCOR_ADDR_SECURITY_CTRL, reg_write_i)
                           && mem_source_i == FCOR_SRC_CPU && mem_from_secure_i;

   fcor_key_store #(
      .DEPTH(8)
   ) u_key_store (
      .clock_i   (clock_i),
      .wr_en_i   (key_prog_en_i),
      .wr_addr_i (key_prog_addr_i),
      .wr_data_i (key_prog_data_i),
      .rd_addr_i (key_index_q),
      .rd_data_o (key_store_rdata)
   );

   // RL12: key only when enabled, in order
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         key_access_q      <= 1'b0;
         key_state_q       <= FCOR_KEY_IDLE;
         key_index_q       <= 3'h0;
         key_mismatch_q    <= 1'b0;
         key_byte_q        <= 8'h00;
         key_cmp_pending_q <= 1'b0;
      end else begin
         key_cmp_pending_q <= key_write;
         if (key_write) begin
            key_byte_q <= reg_wdata_i;
         end
         case (key_state_q)
            FCOR_KEY_IDLE: begin
               if (key_ctrl_write && reg_wdata_i[0] && flash_option_latch_q[`FCOR_BIT_KEY_ENABLE]) begin
                  key_access_q   <= 1'b1;
                  key_index_q    <= 3'h0;
                  key_mismatch_q <= 1'b0;
                  key_state_q    <= FCOR_KEY_COLLECT;
               end
            end
            FCOR_KEY_COLLECT: begin
               if (key_cmp_pending_q) begin
                  if (key_byte_q != key_store_rdata) begin
                     key_mismatch_q <= 1'b1;
                  end
                  key_index_q <= key_index_q + 3'h1;
                  if (key_index_q == 3'h7) begin
                     key_state_q <= FCOR_KEY_DONE;
                  end
               end else if (key_ctrl_write && !reg_wdata_i[0]) begin
                  key_access_q <= 1'b0;
                  key_state_q  <= FCOR_KEY_IDLE;
               end
            end
            FCOR_KEY_DONE: begin
               if (key_ctrl_write && !reg_wdata_i[0]) begin
                  key_access_q <= 1'b0;
                  key_state_q  <= FCOR_KEY_IDLE;
               end
            end
            default: begin
               key_state_q <= FCOR_KEY_IDLE;
            end
         endcase
      end
   end

   // RL17: unlock on key match or blank check
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         security_code_q <= 2'h3;
      end else if (!option_captured_q) begin
         security_code_q <= nonvolatile_option_byte_i[1:0];
      end else if (blank_check_ok_i || (key_state_q == FCOR_KEY_DONE && key_ctrl_write
                                       && !reg_wdata_i[0] && !key_mismatch_q)) begin
         security_code_q <= `FCOR_SECURE_UNLOCKED;
      end
   end

   // ------------------------------------------------------------
   // secure memory gate
   // ------------------------------------------------------------
   logic mem_ok;
   // RL16: deny unsecured sources while secure
   assign mem_ok = unsecured || (mem_source_i == FCOR_SRC_CPU && mem_from_secure_i);

   // RL18: blocked writes dropped, reads zero
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mem_write_en_o <= 1'b0;
         mem_rdata_o    <= 8'h00;
      end else begin
         mem_write_en_o <= mem_write_i && mem_ok;
         mem_rdata_o    <= mem_ok ? mem_rdata_i : 8'h00;
      end
   end

   // RL14: redirection disable and option outputs
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         secure_o              <= 1'b1;
         redirection_disable_o <= 1'b0;
         backdoor_key_enable_o <= 1'b0;
      end else begin
         secure_o              <= !unsecured;
         redirection_disable_o <= flash_option_latch_q[`FCOR_BIT_REDIR_DISABLE];
         backdoor_key_enable_o <= flash_option_latch_q[`FCOR_BIT_KEY_ENABLE];
      end
   end

   // ------------------------------------------------------------
   // register read port
   // ------------------------------------------------------------
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_read_i) begin
         case (reg_addr_i)
            `FCOR_ADDR_CLOCK_DIVIDER: reg_rdata_o <= {divisor_loaded_flag_q, prescale_by_eight_q, divisor_field_q};
            `FCOR_ADDR_OPTION_LATCH:  reg_rdata_o <= {flash_option_latch_q[7:2], security_code_q};
            `FCOR_ADDR_SECURITY_CTRL: reg_rdata_o <= {7'h00, key_access_q};
            `FCOR_ADDR_STATUS:        reg_rdata_o <= {6'h00, !unsecured, key_mismatch_q};
            default:                  reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end
endmodule // fcor_flash_clock_option

// File: fcor_key_store.sv
// small memory holding the eight backdoor key bytes
`timescale 1ns/10ps
module fcor_key_store #(
   parameter int DEPTH = 8
) (
   // clock
   input  wire logic                     clock_i,
   // write port (key programming)
   input  wire logic                     wr_en_i,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
   input  wire logic [7:0]               wr_data_i,
   // read port
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
   output logic      [7:0]               rd_data_o
);
   logic [7:0] mem_q [DEPTH];

   always_ff @(posedge clock_i) begin
      if (wr_en_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      rd_data_o <= mem_q[rd_addr_i];
   end
endmodule // fcor_key_store

// File: fcor_nvm_model.sv
// flash array stand-in: option byte, key bytes and array read data
`timescale 1ns/10ps
module fcor_nvm_model (
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       reset_n_i,
   // option byte and key programming
   output logic [7:0]      option_byte_o,
   output logic            key_prog_en_o,
   output logic [2:0]      key_prog_addr_o,
   output logic [7:0]      key_prog_data_o,
   // array read data
   output logic [7:0]      mem_rdata_o
);
   logic [3:0] key_cnt_q;
   logic [6:0] pat_q;
   initial option_byte_o = 8'hFF;
   task automatic program_option(input logic [7:0] b);
      option_byte_o = b;
   endtask
   function automatic logic [7:0] key_byte(input int i);
      return 8'h5A + 8'(i * 19);
   endfunction
   // key bytes written once after each reset
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) key_cnt_q <= 4'h0;
      else if (!key_cnt_q[3]) key_cnt_q <= key_cnt_q + 4'h1;
   end
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) pat_q <= 7'h00;
      else pat_q <= pat_q + 7'h01;
   end
   assign key_prog_en_o   = reset_n_i && !key_cnt_q[3];
   assign key_prog_addr_o = key_cnt_q[2:0];
   assign key_prog_data_o = key_byte(int'(key_cnt_q[2:0]));
   // never zero, changes every cycle
   assign mem_rdata_o     = {pat_q, 1'b1};
endmodule // fcor_nvm_model

// File: fcor_pkg.sv
// types shared by the flash clock and option register block
package fcor_pkg;
   typedef logic [7:0] fcor_byte_t;
   typedef logic [3:0] fcor_addr_t;
   typedef enum logic {FCOR_SRC_CPU, FCOR_SRC_DEBUG} fcor_source_e;
   typedef enum {FCOR_KEY_IDLE, FCOR_KEY_COLLECT, FCOR_KEY_DONE} fcor_key_state_e;
endpackage

// File: tb_top.sv
// self-checking bench for the flash clock and option register block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("Error %s: expected %h, seen %h", nm, e, g); end end
module tb_top;
   import fcor_pkg::*;
   logic clock_i, reset_n_i, reg_write_i, reg_read_i, op_request_i, blank_check_ok_i;
   logic mem_from_secure_i, mem_write_i, key_prog_en_i, op_allowed_o, op_accept_o, op_blocked_o;
   logic internal_flash_clock_o, flash_pulse_o, mem_write_en_o, secure_o;
   logic redirection_disable_o, backdoor_key_enable_o;
   logic [2:0]   key_prog_addr_i;
   fcor_addr_t   reg_addr_i;
   fcor_byte_t   reg_wdata_i, reg_rdata_o, nonvolatile_option_byte_i, key_prog_data_i, mem_rdata_i, mem_rdata_o;
   fcor_source_e mem_source_i;
   int           n_fail = 0;
   int           total_checks = 0;

   fcor_flash_clock_option i_dut (.clock_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
      .reg_rdata_o, .nonvolatile_option_byte_i, .key_prog_en_i, .key_prog_addr_i, .key_prog_data_i,
      .op_request_i, .blank_check_ok_i, .op_allowed_o, .op_accept_o, .op_blocked_o, .internal_flash_clock_o,
      .flash_pulse_o, .mem_source_i, .mem_from_secure_i, .mem_write_i, .mem_rdata_i, .mem_write_en_o,
      .mem_rdata_o, .secure_o, .redirection_disable_o, .backdoor_key_enable_o);
   fcor_nvm_model i_nvm (.clock_i, .reset_n_i, .option_byte_o(nonvolatile_option_byte_i),
      .key_prog_en_o(key_prog_en_i), .key_prog_addr_o(key_prog_addr_i), .key_prog_data_o(key_prog_data_i),
      .mem_rdata_o(mem_rdata_i));

   always #50 clock_i = ~clock_i;

   task automatic summarize();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic rst(input fcor_byte_t opt);
      i_nvm.program_option(opt);
      @(posedge clock_i);
      reset_n_i <= 1'b0;
      repeat (10) @(posedge clock_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      #1;
   endtask
   task automatic wr(input fcor_addr_t a, input fcor_byte_t d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clock_i);
      reg_write_i <= 1'b0;
   endtask
   task automatic rd(input fcor_addr_t a, input fcor_byte_t e, input string nm);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clock_i);
      reg_read_i <= 1'b0;
      #1 `CHK(nm, e, reg_rdata_o)
   endtask
   task automatic op(input logic ok);
      @(posedge clock_i);
      op_request_i <= 1'b1;
      @(posedge clock_i);
      op_request_i <= 1'b0;
      #1 `CHK("op_accept_o", ok, op_accept_o)
      `CHK("op_blocked_o", !ok, op_blocked_o)
   endtask
   task automatic period(input int e);
      int n = 0;
      int r = 0;
      logic p;
      do begin @(posedge clock_i); #1 n++; end while (flash_pulse_o !== 1'b1 && n < 300);
      n = 0;
      p = internal_flash_clock_o;
      do begin
         @(posedge clock_i);
         #1 n++;
         if (internal_flash_clock_o === 1'b1 && p !== 1'b1) r++;
         p = internal_flash_clock_o;
      end while (flash_pulse_o !== 1'b1 && n < 300);
      `CHK("pulse period", e, n)
      `CHK("flash clock rises", 1, r)
   endtask
   task automatic memchk(input fcor_source_e src, input logic we);
      fcor_byte_t d;
      @(posedge clock_i);
      mem_source_i <= src;
      mem_from_secure_i <= 1'b1;
      mem_write_i <= 1'b1;
      #1 d = mem_rdata_i;
      @(posedge clock_i);
      mem_write_i <= 1'b0;
      #1 `CHK("mem_write_en_o", we, mem_write_en_o)
      if (!we) `CHK("mem_rdata_o", 8'h00, mem_rdata_o)
      else `CHK("mem_rdata_o", d, mem_rdata_o)
   endtask
   task automatic key(input fcor_source_e src, input logic sec);
      @(posedge clock_i);
      mem_source_i <= src;
      mem_from_secure_i <= (src == FCOR_SRC_CPU);
      wr(4'h2, 8'h01);
      for (int i = 0; i < 8; i++) wr(4'h3, i_nvm.key_byte(i));
      wr(4'h2, 8'h00);
      @(posedge clock_i);
      #1 `CHK("secure_o", sec, secure_o)
   endtask

   initial begin
      clock_i = 1'b0; reset_n_i = 1'b0; reg_write_i = 1'b0; reg_read_i = 1'b0; reg_addr_i = 4'h0;
      reg_wdata_i = 8'h00; op_request_i = 1'b0; blank_check_ok_i = 1'b0; mem_source_i = FCOR_SRC_CPU;
      mem_from_secure_i = 1'b0; mem_write_i = 1'b0;
      rst(8'hFF);
      `CHK("secure_o", 1'b1, secure_o)
      `CHK("backdoor_key_enable_o", 1'b1, backdoor_key_enable_o)
      rd(4'h1, 8'hC3, "option");
      wr(4'h1, 8'h00);
      rd(4'h1, 8'hC3, "option kept");
      op(1'b0);
      wr(4'h0, 8'h31);
      rd(4'h0, 8'hB1, "divider");
      wr(4'h0, 8'h45);
      rd(4'h0, 8'hB1, "divider locked");
      op(1'b1);
      period(50);
      memchk(FCOR_SRC_DEBUG, 1'b0);
      memchk(FCOR_SRC_CPU, 1'b1);
      key(FCOR_SRC_DEBUG, 1'b1);
      rd(4'h3, 8'h02, "status secure");
      key(FCOR_SRC_CPU, 1'b0);
      rd(4'h3, 8'h00, "status open");
      rd(4'h2, 8'h00, "key access off");
      rd(4'h1, 8'hC2, "option unlocked");
      memchk(FCOR_SRC_DEBUG, 1'b1);
      $display("test secure key done");
      rst(8'h42);
      `CHK("secure_o", 1'b0, secure_o)
      `CHK("redirection_disable_o", 1'b1, redirection_disable_o)
      rd(4'h1, 8'h42, "option loaded");
      wr(4'h0, 8'h46);
      period(56);
      $display("test prescale done");
      rst(8'h01);
      key(FCOR_SRC_CPU, 1'b1);
      @(posedge clock_i);
      blank_check_ok_i <= 1'b1;
      @(posedge clock_i);
      blank_check_ok_i <= 1'b0;
      @(posedge clock_i);
      #1 `CHK("secure_o", 1'b0, secure_o)
      $display("test blank check done");
      summarize();
   end
   initial begin
      #6000000;
      n_fail++;
      $display("Error run limit reached");
      summarize();
   end
endmodule // tb_top
